// ### verilog/diag_consts.svh
/*
  Constants for the two-wire diagnostic target: bus addresses, memory map,
  field positions and counts. Assumes inclusion by every design file that
  needs a number; holds definitions only.
*/
// Contract
// - Answer at bus address 1010000X with a 256-byte identification memory.
// - Answer at bus address 1010001X with a separate diagnostic memory.
// - Capture data on serial clock rise; write only unprotected memory segments.
// - Change outgoing data on the serial clock fall.
// - Data line is two-way; host marks start and stop with data and clock.
// - Both memories are 8-bit words, reached singly or sequentially.
// - Diagnostic byte 110 bit 1 reads the inverse of loss of light.
// - Temperature, bias, transmit power, receive power and supply are readable.
// - Alarm and warning flags set when a value leaves its programmed range.
// - Report both internal and external calibration schemes.
// - Signal-present output high in normal reception, low on no light.
`ifndef DIAG_CONSTS_SVH
`define DIAG_CONSTS_SVH

`define DEV_ADDR_ID      7'h50
`define DEV_ADDR_DIAG    7'h51
`define BYTE_BITS        4'h8
`define NUM_CHAN         5

`define ID_CAL_MODE      8'h5c
`define ID_CAL_EXT_BIT   4
`define ID_CAL_INT_BIT   5

`define THRESH_LAST      8'h27
`define MEAS_FIRST       8'h60
`define MEAS_LAST        8'h69
`define STATUS_CTRL      8'h6e
`define STATUS_SIG_BIT   1
`define STATUS_SOFT_BIT  6
`define ALARM_BYTE0      8'h70
`define ALARM_BYTE1      8'h71
`define WARN_BYTE0       8'h74
`define WARN_BYTE1       8'h75
`define USER_FIRST       8'h80

`endif

// ### verilog/diag_pkg.sv
/*
  Types for the two-wire diagnostic target. Assumes the constants header is
  available for numbers; this package holds only types.
*/
package diag_pkg;

    typedef enum logic [3:0] {
        ST_IDLE       = 4'h0,
        ST_DEV_ADDR   = 4'h1,
        ST_DEV_ACK    = 4'h2,
        ST_WORD_ADDR  = 4'h3,
        ST_WADDR_ACK  = 4'h4,
        ST_WRITE_DATA = 4'h5,
        ST_WRITE_ACK  = 4'h6,
        ST_READ_DATA  = 4'h7,
        ST_READ_ACK   = 4'h8,
        ST_IGNORE     = 4'h9
    } link_state_e;

    typedef logic [15:0] meas_t;

endpackage

// ### verilog/mem_port_if.sv
/*
  Word access port between the serial engine and the memories. Assumes one
  clock domain; the write strobe is a single-cycle pulse.
*/
`timescale 1ns/100ps
interface mem_port_if;
    logic       diag_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic [7:0] rdata;

    modport ctrl (output diag_sel, output addr, output wdata, output wr, input rdata);
    modport mem  (input diag_sel, input addr, input wdata, input wr, output rdata);
endinterface

// ### verilog/pin_sync.sv
/*
  Two-stage synchroniser for a group of pin inputs. Assumes inputs are
  asynchronous to clk; only the second stage may be read.
*/
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Pins and synchronised levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta_reg;
            logic hold_reg;
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    meta_reg <= 1'b1;
                    hold_reg <= 1'b1;
                end
                else
                begin
                    meta_reg <= pin_in[i];
                    hold_reg <= meta_reg;
                end
            end
            assign level_out[i] = hold_reg;
        end
    endgenerate
endmodule

// ### verilog/diag_memory.sv
/*
  Identification and diagnostic memories with live measurement, status and
  flag bytes. Assumes measurement values come from logic on the same clock
  and that threshold bytes are loaded while factory_unlock is high.
*/
`timescale 1ns/100ps
`include "diag_consts.svh"
module diag_memory
    import diag_pkg::*;
(
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  reset_n,
    // Word port
    mem_port_if.mem    port,
    // Live inputs
    input  wire meas_t meas_in [`NUM_CHAN],
    input  wire logic  signal_present,
    input  wire logic  cal_external,
    input  wire logic  factory_unlock
);
    logic [7:0] id_mem   [256];
    logic [7:0] diag_mem [256];
    meas_t      meas_reg [`NUM_CHAN];
    logic [9:0] alarm_reg;
    logic [9:0] alarm_next;
    logic [9:0] warn_reg;
    logic [9:0] warn_next;
    logic       soft_dis_reg;
    logic       soft_dis_next;
    logic       diag_wp;
    logic [7:0] meas_idx;

    // Flag bit 9-2c is high-side, 8-2c is low-side for channel c
    genvar c;
    generate
        for (c = 0; c < `NUM_CHAN; c++)
        begin : g_chan
            logic [15:0] hi_alarm;
            logic [15:0] lo_alarm;
            logic [15:0] hi_warn;
            logic [15:0] lo_warn;
            assign hi_alarm = {diag_mem[8*c], diag_mem[8*c+1]};
            assign lo_alarm = {diag_mem[8*c+2], diag_mem[8*c+3]};
            assign hi_warn  = {diag_mem[8*c+4], diag_mem[8*c+5]};
            assign lo_warn  = {diag_mem[8*c+6], diag_mem[8*c+7]};
            // Temperature is two's complement, the rest are unsigned
            if (c == 0)
            begin : g_signed
                assign alarm_next[9-2*c] = $signed(meas_reg[c]) > $signed(hi_alarm);
                assign alarm_next[8-2*c] = $signed(meas_reg[c]) < $signed(lo_alarm);
                assign warn_next[9-2*c]  = $signed(meas_reg[c]) > $signed(hi_warn);
                assign warn_next[8-2*c]  = $signed(meas_reg[c]) < $signed(lo_warn);
            end
            else
            begin : g_unsigned
                assign alarm_next[9-2*c] = meas_reg[c] > hi_alarm;
                assign alarm_next[8-2*c] = meas_reg[c] < lo_alarm;
                assign warn_next[9-2*c]  = meas_reg[c] > hi_warn;
                assign warn_next[8-2*c]  = meas_reg[c] < lo_warn;
            end
        end
    endgenerate

    // Factory areas are locked while factory_unlock is low; the user area is always open
    assign diag_wp       = !factory_unlock && (port.addr < `USER_FIRST);
    assign soft_dis_next = (port.wr && port.diag_sel && port.addr == `STATUS_CTRL)
                         ? port.wdata[`STATUS_SOFT_BIT] : soft_dis_reg;
    assign meas_idx      = port.addr - `MEAS_FIRST;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            alarm_reg    <= 10'h000;
            warn_reg     <= 10'h000;
            soft_dis_reg <= 1'b0;
            for (int i = 0; i < `NUM_CHAN; i++)
                meas_reg[i] <= 16'h0000;
        end
        else
        begin
            alarm_reg    <= alarm_next;
            warn_reg     <= warn_next;
            soft_dis_reg <= soft_dis_next;
            for (int i = 0; i < `NUM_CHAN; i++)
                meas_reg[i] <= meas_in[i];
        end
    end

    // Arrays carry no reset; contents are loaded over the link
    always_ff @(posedge clk)
    begin
        if (port.wr && !port.diag_sel && factory_unlock)
            id_mem[port.addr] <= port.wdata;
        if (port.wr && port.diag_sel && !diag_wp)
            diag_mem[port.addr] <= port.wdata;
    end

    always_comb
    begin
        port.rdata = port.diag_sel ? diag_mem[port.addr] : id_mem[port.addr];
        if (!port.diag_sel && port.addr == `ID_CAL_MODE)
        begin
            port.rdata[`ID_CAL_EXT_BIT] = cal_external;
            port.rdata[`ID_CAL_INT_BIT] = !cal_external;
        end
        else if (port.diag_sel)
        begin
            if (port.addr >= `MEAS_FIRST && port.addr <= `MEAS_LAST)
                port.rdata = meas_idx[0] ? meas_reg[meas_idx[3:1]][7:0]
                                         : meas_reg[meas_idx[3:1]][15:8];
            else if (port.addr == `STATUS_CTRL)
                port.rdata = {1'b0, soft_dis_reg, 4'h0, signal_present, 1'b0};
            else if (port.addr == `ALARM_BYTE0)
                port.rdata = alarm_reg[9:2];
            else if (port.addr == `ALARM_BYTE1)
                port.rdata = {alarm_reg[1:0], 6'h00};
            else if (port.addr == `WARN_BYTE0)
                port.rdata = warn_reg[9:2];
            else if (port.addr == `WARN_BYTE1)
                port.rdata = {warn_reg[1:0], 6'h00};
        end
    end

    property p_status_bit;
        @(posedge clk) disable iff (!reset_n)
        (port.diag_sel && port.addr == `STATUS_CTRL) |-> port.rdata[`STATUS_SIG_BIT] == signal_present;
    endproperty
    a_status_bit: assert property (p_status_bit) else $error("status bit differs from signal present");

    property p_wp_hold;
        @(posedge clk) disable iff (!reset_n)
        (port.wr && port.diag_sel && diag_wp) |=> diag_mem[$past(port.addr)] == $past(diag_mem[port.addr]);
    endproperty
    a_wp_hold: assert property (p_wp_hold) else $error("protected byte was written");

    property p_temp_alarm;
        @(posedge clk) disable iff (!reset_n)
        ($signed(meas_reg[0]) > $signed({diag_mem[0], diag_mem[1]})) ##1 $stable(meas_reg[0]) |-> alarm_reg[9];
    endproperty
    a_temp_alarm: assert property (p_temp_alarm) else $error("high temperature alarm missing");

    property p_meas_read;
        @(posedge clk) disable iff (!reset_n)
        (port.diag_sel && port.addr == `MEAS_FIRST) |-> port.rdata == $past(meas_in[0][15:8]);
    endproperty
    a_meas_read: assert property (p_meas_read) else $error("temperature byte differs from sample");
endmodule

// ### verilog/diag_two_wire_target.sv
/*
  Two-wire serial target: start and stop detection, address match, word
  pointer, byte shifting and open-drain data drive, plus the signal-present
  output. Assumes SCL, SDA and all straps arrive asynchronously and are
  sampled by SYS_CLK well above the serial clock rate.
*/
`timescale 1ns/100ps
`include "diag_consts.svh"
module diag_two_wire_target
    import diag_pkg::*;
(
    // Clock and reset
    input  wire logic  SYS_CLK,
    input  wire logic  RESET_N,
    // Serial link
    input  wire logic  SCL_IN,
    input  wire logic  SDA_IN,
    output logic       SDA_OUT,
    output logic       SDA_OE,
    // Optical status
    input  wire logic  LOSS_OF_LIGHT,
    output logic       SIGNAL_PRESENT,
    // Straps
    input  wire logic  CAL_EXTERNAL,
    input  wire logic  FACTORY_UNLOCK,
    // Measurements from the diagnostics controller
    input  wire meas_t TEMP_VALUE,
    input  wire meas_t SUPPLY_VALUE,
    input  wire meas_t BIAS_VALUE,
    input  wire meas_t TX_POWER_VALUE,
    input  wire meas_t RX_POWER_VALUE
);
    logic [4:0]  sync_level;
    logic        scl_s;
    logic        sda_s;
    logic        dark_s;
    logic        cal_ext_s;
    logic        unlock_s;
    meas_t       meas_bus [`NUM_CHAN];

    link_state_e state_reg;
    link_state_e state_next;
    logic [3:0]  bit_cnt_reg;
    logic [3:0]  bit_cnt_next;
    logic [7:0]  shift_reg;
    logic [7:0]  shift_next;
    logic [7:0]  ptr_reg;
    logic [7:0]  ptr_next;
    logic        diag_sel_reg;
    logic        diag_sel_next;
    logic        sda_oe_reg;
    logic        sda_oe_next;
    logic        wr_reg;
    logic        wr_next;
    logic        scl_d_reg;
    logic        sda_d_reg;
    logic        sig_present_reg;

    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic        addr_hit;
    logic        byte_done;

    mem_port_if  mem_bus ();

    pin_sync #(
        .WIDTH     (5)
    ) u_sync (
        .clk       (SYS_CLK),
        .reset_n   (RESET_N),
        .pin_in    ({SCL_IN, SDA_IN, LOSS_OF_LIGHT, CAL_EXTERNAL, FACTORY_UNLOCK}),
        .level_out (sync_level)
    );

    assign scl_s     = sync_level[4];
    assign sda_s     = sync_level[3];
    assign dark_s    = sync_level[2];
    assign cal_ext_s = sync_level[1];
    assign unlock_s  = sync_level[0];

    assign meas_bus[0] = TEMP_VALUE;
    assign meas_bus[1] = SUPPLY_VALUE;
    assign meas_bus[2] = BIAS_VALUE;
    assign meas_bus[3] = TX_POWER_VALUE;
    assign meas_bus[4] = RX_POWER_VALUE;

    diag_memory u_memory (
        .clk            (SYS_CLK),
        .reset_n        (RESET_N),
        .port           (mem_bus.mem),
        .meas_in        (meas_bus),
        .signal_present (sig_present_reg),
        .cal_external   (cal_ext_s),
        .factory_unlock (unlock_s)
    );

    assign mem_bus.diag_sel = diag_sel_reg;
    assign mem_bus.addr     = ptr_reg;
    assign mem_bus.wdata    = shift_reg;
    assign mem_bus.wr       = wr_reg;

    // Serial clock edges seen through the synchroniser
    assign scl_rise  = scl_s && !scl_d_reg;
    assign scl_fall  = !scl_s && scl_d_reg;
    // Data moving while the clock is high frames a transfer
    assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    assign byte_done = scl_fall && (bit_cnt_reg == `BYTE_BITS);
    assign addr_hit  = (shift_reg[7:1] == `DEV_ADDR_ID) || (shift_reg[7:1] == `DEV_ADDR_DIAG);

    always_comb
    begin
        state_next    = state_reg;
        bit_cnt_next  = bit_cnt_reg;
        shift_next    = shift_reg;
        ptr_next      = ptr_reg;
        diag_sel_next = diag_sel_reg;
        sda_oe_next   = sda_oe_reg;
        wr_next       = 1'b0;
        if (wr_reg)
            ptr_next = ptr_reg + 8'h01;
        if (start_det)
        begin
            state_next   = ST_DEV_ADDR;
            bit_cnt_next = 4'h0;
            sda_oe_next  = 1'b0;
        end
        else if (stop_det)
        begin
            state_next  = ST_IDLE;
            sda_oe_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_DEV_ADDR, ST_WORD_ADDR, ST_WRITE_DATA:
                begin
                    if (scl_rise)
                    begin
                        shift_next   = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        bit_cnt_next = 4'h0;
                        sda_oe_next  = 1'b1;
                        if (state_reg == ST_DEV_ADDR)
                        begin
                            if (addr_hit)
                            begin
                                state_next    = ST_DEV_ACK;
                                diag_sel_next = shift_reg[1];
                            end
                            else
                            begin
                                state_next  = ST_IGNORE;
                                sda_oe_next = 1'b0;
                            end
                        end
                        else if (state_reg == ST_WORD_ADDR)
                        begin
                            state_next = ST_WADDR_ACK;
                            ptr_next   = shift_reg;
                        end
                        else
                        begin
                            state_next = ST_WRITE_ACK;
                            wr_next    = 1'b1;
                        end
                    end
                end
                ST_DEV_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (shift_reg[0])
                        begin
                            // First read byte drives its top bit on this same fall
                            state_next  = ST_READ_DATA;
                            shift_next  = {mem_bus.rdata[6:0], 1'b0};
                            sda_oe_next = !mem_bus.rdata[7];
                        end
                        else
                        begin
                            state_next  = ST_WORD_ADDR;
                            sda_oe_next = 1'b0;
                        end
                    end
                end
                ST_WADDR_ACK, ST_WRITE_ACK:
                begin
                    if (scl_fall)
                    begin
                        state_next  = ST_WRITE_DATA;
                        sda_oe_next = 1'b0;
                    end
                end
                ST_READ_DATA:
                begin
                    if (scl_rise)
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    else if (byte_done)
                    begin
                        state_next   = ST_READ_ACK;
                        sda_oe_next  = 1'b0;
                        bit_cnt_next = 4'h0;
                        ptr_next     = ptr_reg + 8'h01;
                    end
                    else if (scl_fall)
                    begin
                        sda_oe_next = !shift_reg[7];
                        shift_next  = {shift_reg[6:0], 1'b0};
                    end
                end
                ST_READ_ACK:
                begin
                    if (scl_rise && sda_s)
                        state_next = ST_IGNORE;
                    else if (scl_fall)
                    begin
                        state_next  = ST_READ_DATA;
                        shift_next  = {mem_bus.rdata[6:0], 1'b0};
                        sda_oe_next = !mem_bus.rdata[7];
                    end
                end
                ST_IDLE, ST_IGNORE:
                begin
                    sda_oe_next = 1'b0;
                end
                default:
                begin
                    state_next  = ST_IDLE;
                    sda_oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state_reg       <= ST_IDLE;
            bit_cnt_reg     <= 4'h0;
            shift_reg       <= 8'h00;
            ptr_reg         <= 8'h00;
            diag_sel_reg    <= 1'b0;
            sda_oe_reg      <= 1'b0;
            wr_reg          <= 1'b0;
            scl_d_reg       <= 1'b1;
            sda_d_reg       <= 1'b1;
            sig_present_reg <= 1'b0;
        end
        else
        begin
            state_reg       <= state_next;
            bit_cnt_reg     <= bit_cnt_next;
            shift_reg       <= shift_next;
            ptr_reg         <= ptr_next;
            diag_sel_reg    <= diag_sel_next;
            sda_oe_reg      <= sda_oe_next;
            wr_reg          <= wr_next;
            scl_d_reg       <= scl_s;
            sda_d_reg       <= sda_s;
            sig_present_reg <= !dark_s;
        end
    end

    // Open drain: only a low is ever driven, and no clock line exists here
    assign SDA_OUT        = 1'b0;
    assign SDA_OE         = sda_oe_reg;
    assign SIGNAL_PRESENT = sig_present_reg;

    property p_ignore_released;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (state_reg == ST_IGNORE) |-> !SDA_OE;
    endproperty
    a_ignore_released: assert property (p_ignore_released) else $error("data driven for foreign address");

    property p_addr_ack;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (state_reg == ST_DEV_ADDR && byte_done && !start_det && !stop_det && addr_hit)
            |=> (state_reg == ST_DEV_ACK) && SDA_OE && (diag_sel_reg == $past(shift_reg[1]));
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

    property p_miss_ignored;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (state_reg == ST_DEV_ADDR && byte_done && !start_det && !stop_det && !addr_hit)
            |=> (state_reg == ST_IGNORE) && !SDA_OE;
    endproperty
    a_miss_ignored: assert property (p_miss_ignored) else $error("foreign address not ignored");

    property p_capture_rise;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (scl_rise && !start_det && (state_reg == ST_WORD_ADDR || state_reg == ST_WRITE_DATA))
            |=> shift_reg[0] == $past(sda_s);
    endproperty
    a_capture_rise: assert property (p_capture_rise) else $error("data not captured on rise");

    property p_change_on_fall;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        $rose(SDA_OE) |-> $past(scl_fall);
    endproperty
    a_change_on_fall: assert property (p_change_on_fall) else $error("data driven off a falling edge");

    property p_read_advance;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (state_reg == ST_READ_DATA && byte_done && !start_det && !stop_det)
            |=> (ptr_reg == $past(ptr_reg) + 8'h01) && (state_reg == ST_READ_ACK);
    endproperty
    a_read_advance: assert property (p_read_advance) else $error("pointer not advanced after read");

    property p_write_advance;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        wr_reg |-> ##1 ptr_reg == $past(ptr_reg) + 8'h01;
    endproperty
    a_write_advance: assert property (p_write_advance) else $error("pointer not advanced after write");

    property p_start_frame;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        start_det |=> (state_reg == ST_DEV_ADDR) && (bit_cnt_reg == 4'h0) && !SDA_OE;
    endproperty
    a_start_frame: assert property (p_start_frame) else $error("start not taken");

    property p_signal_present;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        $rose(dark_s) |=> !SIGNAL_PRESENT;
    endproperty
    a_signal_present: assert property (p_signal_present) else $error("signal present stays high on loss");
endmodule

// ### test/host_model.sv
/*
  Two-wire host model: makes the serial clock, start, stop and bytes.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/100ps
module host_model (
    // Clock and wire
    input  wire logic clk,
    input  wire logic sda,
    // Drives
    output logic      scl = 1,
    output logic      sda_low = 0
);
    // Changes land two clocks apart: a 320 ns serial clock with four-clock phases
    task automatic step(input logic c, input logic l);
        repeat (2) @(posedge clk);
        scl <= c;
        sda_low <= l;
    endtask
    task automatic start;
        step(0, sda_low);
        step(0, 0);
        step(1, 0);
        step(1, 1);
    endtask
    task automatic stop;
        step(0, sda_low);
        step(0, 1);
        step(1, 1);
        step(1, 0);
    endtask
    task automatic bit_x(input logic b, output logic r);
        step(0, sda_low);
        step(0, !b);
        step(1, !b);
        repeat (2) @(posedge clk);
        r = sda;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(d[i], r);
            q = {q[6:0], r};
        end
        bit_x(ak, a);
    endtask
endmodule

// ### test/test_diag_two_wire_target.sv
/*
  Bench for the two-wire target: memories, protection, live bytes, pointer.
  Assumes the host model drives the serial side.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; $display("ERROR %0t: got %h exp %h", $time, a, e); end end
module test_diag_two_wire_target;
    import diag_pkg::*;
    logic       sys_clk = 0, reset_n = 0, loss = 0, cal_ext = 0, unlock = 0, ack, sda_oe, sda_out, sig_present, scl, sda_low;
    meas_t      temp = 16'h0000, other = 16'h0000;
    logic [7:0] q0, q1, junk;
    int         fail_count = 0, checks = 0, cycles = 0;
    wire        sda = !(sda_low || (sda_oe && !sda_out));

    diag_two_wire_target i_diag_two_wire_target (.SYS_CLK(sys_clk), .RESET_N(reset_n), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .LOSS_OF_LIGHT(loss), .SIGNAL_PRESENT(sig_present),
        .CAL_EXTERNAL(cal_ext), .FACTORY_UNLOCK(unlock), .TEMP_VALUE(temp), .SUPPLY_VALUE(other),
        .BIAS_VALUE(other), .TX_POWER_VALUE(other), .RX_POWER_VALUE(other));
    host_model i_host_model (.clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    initial forever #20 sys_clk = ~sys_clk;

    task automatic sb(input logic [7:0] d, input logic a_exp);
        i_host_model.xfer(d, 1'b1, junk, ack);
        `CHK(ack, !a_exp)
    endtask
    task automatic wr(input logic [7:0] dev, a, d0, d1);
        i_host_model.start();
        sb(dev, 1);
        sb(a, 1);
        sb(d0, 1);
        sb(d1, 1);
        i_host_model.stop();
    endtask
    task automatic rd(input logic [7:0] dev, a, output logic [7:0] r0, r1);
        i_host_model.start();
        sb(dev, 1);
        sb(a, 1);
        i_host_model.start();
        sb(dev | 8'h01, 1);
        i_host_model.xfer(8'hff, 1'b0, r0, ack);
        i_host_model.xfer(8'hff, 1'b1, r1, ack);
        i_host_model.stop();
    endtask
    task automatic t_map;
        unlock <= 1;
        wr(8'ha0, 8'h00, 8'h3c, 8'hc3);
        wr(8'ha2, 8'h00, 8'h10, 8'h00);
        wr(8'ha2, 8'h6e, 8'h40, 8'h00);
        unlock <= 0;
        wr(8'ha0, 8'h00, 8'h55, 8'h66);
        wr(8'ha2, 8'h00, 8'h55, 8'h66);
        rd(8'ha0, 8'h00, q0, q1);
        `CHK({q0, q1}, 16'h3cc3)
        rd(8'ha2, 8'h00, q0, q1);
        `CHK({q0, q1}, 16'h1000)
        $display("t_map done");
    endtask
    task automatic t_live;
        temp <= 16'h1234;
        loss <= 1;
        rd(8'ha2, 8'h60, q0, q1);
        `CHK({q0, q1}, 16'h1234)
        rd(8'ha2, 8'h6e, q0, q1);
        `CHK(q0[1], 1'b0)
        `CHK(sig_present, 1'b0)
        rd(8'ha2, 8'h70, q0, q1);
        `CHK(q0[7], 1'b1)
        loss <= 0;
        rd(8'ha2, 8'h6e, q0, q1);
        `CHK(q0[1], 1'b1)
        `CHK(q0, 8'h42)
        `CHK(sig_present, 1'b1)
        $display("t_live done");
    endtask
    task automatic t_seq;
        wr(8'ha2, 8'h80, 8'h5a, 8'ha5);
        rd(8'ha2, 8'h80, q0, q1);
        `CHK({q0, q1}, 16'h5aa5)
        $display("t_seq done");
    endtask
    task automatic t_cal;
        cal_ext <= 1;
        rd(8'ha0, 8'h5c, q0, q1);
        `CHK(q0[5:4], 2'b01)
        cal_ext <= 0;
        rd(8'ha0, 8'h5c, q0, q1);
        `CHK(q0[5:4], 2'b10)
        $display("t_cal done");
    endtask
    task automatic t_other;
        i_host_model.start();
        sb(8'hb0, 0);
        i_host_model.stop();
        $display("t_other done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // About 5400 cycles of traffic are expected
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fail_count++;
            tally_and_finish;
        end
    end

    initial
    begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1;
        repeat (4) @(posedge sys_clk);
        t_map;
        t_live;
        t_seq;
        t_cal;
        t_other;
        tally_and_finish;
    end
endmodule
